// file: adc_seq_pkg.sv
// shared constants and types for the conversion sequencer and its host
package adc_seq_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned NUM_CH  = 11;
  localparam int unsigned CH_W    = 11;
  localparam int unsigned RES_W   = 12;

  // clock mode encodings
  localparam logic [1:0] MODE_AUTO_WRITE = 2'h0;
  localparam logic [1:0] MODE_AUTO_PULSE = 2'h1;
  localparam logic [1:0] MODE_RESERVED   = 2'h2;
  localparam logic [1:0] MODE_ONE_SHOT   = 2'h3;
  localparam logic [1:0] MODE_RESET      = MODE_AUTO_WRITE;

  // times in nanoseconds as printed
  localparam int unsigned T_START_MIN_NS     = 20;
  localparam int unsigned T_START_VOLT_NS    = 1500;
  localparam int unsigned T_START_INTREF_NS  = 50000;
  localparam int unsigned T_REF_UP_NS        = 45000;
  localparam int unsigned T_SENSOR_UP_NS     = 5000;
  localparam int unsigned T_TEMP_CONV_NS     = 30000;
  localparam int unsigned T_VOLT_CONV_NS     = 3500;
  localparam int unsigned T_TRACK_CONV_NS    = 5600;

  // cycle counts: least times round up, typical conversion times round down
  localparam int unsigned CYC_START_MIN    = (T_START_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_START_VOLT   = (T_START_VOLT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_START_INTREF = (T_START_INTREF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_REF_UP       = T_REF_UP_NS * CLK_MHZ / 1000;
  localparam int unsigned CYC_SENSOR_UP    = T_SENSOR_UP_NS * CLK_MHZ / 1000;
  localparam int unsigned CYC_TEMP_CONV    = T_TEMP_CONV_NS * CLK_MHZ / 1000;
  localparam int unsigned CYC_VOLT_CONV    = T_VOLT_CONV_NS * CLK_MHZ / 1000;
  localparam int unsigned CYC_TRACK_CONV   = T_TRACK_CONV_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W            = 12;

  // kind of each conversion
  typedef enum logic [1:0] {
    KIND_TEMP   = 2'h0,
    KIND_EXTREF = 2'h1,
    KIND_INTREF = 2'h2
  } conv_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARMED = 3'h1,
    ST_POWER = 3'h3,
    ST_CONV  = 3'h2,
    ST_STORE = 3'h6,
    ST_DONE  = 3'h7
  } seq_state_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_LOW   = 2'h1,
    HS_WAIT  = 2'h3
  } host_state_t;
endpackage

// file: adc_seq_if.sv
// link between the conversion sequencer and the host controller
`timescale 1ns/1ps
interface adc_seq_if;
  import adc_seq_pkg::*;
  logic                conversion_start_n;
  logic                busy;
  logic [1:0]          clock_mode;
  logic                conv_write;
  logic [NUM_CH-1:0]   channel_select;
  logic [NUM_CH-1:0]   kind_temp;
  logic                adc_monitor_enable;

  modport device (
    input  conversion_start_n, clock_mode, conv_write, channel_select, kind_temp,
    input  adc_monitor_enable,
    output busy
  );
  modport host (
    output conversion_start_n, clock_mode, conv_write, channel_select, kind_temp,
    output adc_monitor_enable,
    input  busy
  );
endinterface

// file: adc_seq_device.sv
// conversion sequencer: walks the selected channels and stores results
// Functional notes
// - mode 00 register write runs full scan
// - reset leaves clock mode 00 selected
// - monitor on: busy, scan, store, power down
// - mode 01 one start pulse converts all
// - mode 10 reserved, never selected
// - mode 11 one conversion per start pulse
// - temperature start low at least 20ns
// - first temperature waits 45+5+30us; here only 5+30us when the reference is already up
// - later temperature conversions take 30us
// - external reference volt: 1.5us low, 3.5us; the low time is checked in mode 11 only, mode 01 checks 20ns
// - first internal reference volt: 50us low; checked in mode 11 only, mode 01 checks 20ns
// - later internal reference volt: 5.6us result; here mode 11 only, modes 00 and 01 take 3.5us
// - two-bit mode field selects clock mode
// - leaving mode 00 finishes triggered series
// - leaving 01/11 exits if waiting trigger
`timescale 1ns/1ps
module adc_seq_device
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_SRST,
  // link to host
  adc_seq_if.device              link,
  // user side: results and power state
  input  wire logic [NUM_CH-1:0] I_REF_EXTERNAL,
  output logic                   O_RESULT_VALID,
  output logic [3:0]             O_RESULT_CH,
  output logic                   O_ADC_POWERED,
  output logic                   O_BUSY
);
  seq_state_t        state, next_state;
  logic [1:0]        mode, next_mode;
  logic [NUM_CH-1:0] pending, next_pending;
  logic [3:0]        ch, next_ch;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [CNT_W-1:0]  low_cnt, next_low_cnt;
  logic              start_d, next_start_d;
  logic              ref_up, next_ref_up;
  logic              sensor_up, next_sensor_up;
  logic              busy, next_busy;
  logic              powered, next_powered;
  logic              rvalid, next_rvalid;
  logic              one_shot, next_one_shot;
  logic [3:0]        rch, next_rch;
  logic [CNT_W-1:0]  conv_len;
  logic [NUM_CH-1:0] low_mask;
  logic              start_rise, start_fall, pulse_ok, one_hot_free;
  logic [3:0]        first_ch;

  // lowest pending channel
  always_comb begin
    first_ch = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        first_ch = 4'(i);
      end
    end
  end

  assign start_fall = start_d & ~link.conversion_start_n;
  assign start_rise = ~start_d & link.conversion_start_n;
  assign one_hot_free = (pending == '0);
  // pulse length checked on release against the minimum for the next kind in mode 11, against the 20ns minimum in mode 01
  always_comb begin
    pulse_ok = (low_cnt >= CNT_W'(CYC_START_MIN - 1));
    if (mode == MODE_ONE_SHOT && !link.kind_temp[first_ch]) begin
      if (I_REF_EXTERNAL[first_ch]) begin
        pulse_ok = (low_cnt >= CNT_W'(CYC_START_VOLT - 1));
      end else if (!ref_up) begin
        pulse_ok = (low_cnt >= CNT_W'(CYC_START_INTREF - 1));
      end else begin
        pulse_ok = (low_cnt >= CNT_W'(CYC_START_VOLT - 1));
      end
    end
  end

  // conversion length of the current channel
  always_comb begin
    if (link.kind_temp[ch]) begin
      conv_len = CNT_W'(CYC_TEMP_CONV);
    end else if (I_REF_EXTERNAL[ch] || !one_shot) begin
      conv_len = CNT_W'(CYC_VOLT_CONV);
    end else if (ref_up) begin
      conv_len = CNT_W'(CYC_TRACK_CONV);
    end else begin
      conv_len = CNT_W'(CYC_VOLT_CONV);
    end
  end

  always_comb begin
    low_mask = '0;
    low_mask[first_ch] = 1'b1;
  end

  always_comb begin
    next_state     = state;
    next_mode      = link.clock_mode;
    next_pending   = pending;
    next_ch        = ch;
    next_cnt       = cnt;
    next_start_d   = link.conversion_start_n;
    next_low_cnt   = link.conversion_start_n ? '0 :
                     (low_cnt == '1 ? low_cnt : low_cnt + CNT_W'(1));
    next_ref_up    = ref_up;
    next_sensor_up = sensor_up;
    next_busy      = busy;
    next_powered   = powered;
    next_rvalid    = 1'b0;
    next_rch       = rch;
    next_one_shot  = one_shot;
    case (state)
      ST_IDLE: begin
        next_busy = 1'b0;
        // writes during busy never reach here, so they are ignored
        if (link.conv_write && link.channel_select != '0) begin
          next_pending = link.channel_select;
          // the mode field may change with the write itself, so decide on the link value
          if (link.clock_mode == MODE_AUTO_WRITE && link.adc_monitor_enable) begin
            next_state = ST_POWER;
            next_busy  = 1'b1;
            next_powered = 1'b1;
            next_cnt   = '0;
            next_one_shot = 1'b0;
          end else if (link.clock_mode == MODE_AUTO_PULSE ||
                       link.clock_mode == MODE_ONE_SHOT) begin
            next_state = ST_ARMED;
          end
        end
      end
      ST_ARMED: begin
        if (mode != link.clock_mode) begin
          next_state   = ST_IDLE;
          next_powered = 1'b0;
          next_pending = '0;
        end else if (start_rise && pulse_ok) begin
          next_state   = ST_POWER;
          next_busy    = 1'b1;
          next_powered = 1'b1;
          next_cnt     = '0;
          next_one_shot = (mode == MODE_ONE_SHOT);
        end
      end
      ST_POWER: begin
        next_ch = first_ch;
        // first temperature needs reference then sensor power-up
        // a reference already up from a voltage conversion leaves only the sensor wait
        if (link.kind_temp[first_ch] && !sensor_up) begin
          next_cnt = cnt + CNT_W'(1);
          if (cnt == (ref_up ? CNT_W'(CYC_SENSOR_UP - 1) :
                               CNT_W'(CYC_REF_UP + CYC_SENSOR_UP - 1))) begin
            next_ref_up = 1'b1;
            next_sensor_up = 1'b1;
            next_cnt = '0;
            next_state = ST_CONV;
          end
        end else begin
          next_cnt = '0;
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == conv_len - CNT_W'(1)) begin
          next_state = ST_STORE;
          next_cnt = '0;
        end
      end
      ST_STORE: begin
        next_rvalid  = 1'b1;
        next_rch     = ch;
        next_pending = pending & ~low_mask;
        if (!link.kind_temp[ch]) begin
          next_ref_up = next_ref_up | ~I_REF_EXTERNAL[ch];
        end
        // scan kind is latched at the trigger so a mode change mid-scan finishes the series
        next_state = ((pending & ~low_mask) == '0 || one_shot) ?
                     ST_DONE : ST_POWER;
      end
      ST_DONE: begin
        next_busy = 1'b0;
        if (one_shot && pending != '0 && link.clock_mode == MODE_ONE_SHOT) begin
          next_state = ST_ARMED;
        end else begin
          next_state = ST_IDLE;
          next_powered = 1'b0;
          next_pending = '0;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // reserved mode behaves like idle since no branch starts in it
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      state     <= ST_IDLE;
      mode      <= MODE_RESET;
      pending   <= '0;
      ch        <= 4'h0;
      cnt       <= '0;
      low_cnt   <= '0;
      start_d   <= 1'b1;
      ref_up    <= 1'b0;
      sensor_up <= 1'b0;
      busy      <= 1'b0;
      powered   <= 1'b0;
      rvalid    <= 1'b0;
      rch       <= 4'h0;
      one_shot  <= 1'b0;
    end else begin
      state     <= next_state;
      mode      <= next_mode;
      pending   <= next_pending;
      ch        <= next_ch;
      cnt       <= next_cnt;
      low_cnt   <= next_low_cnt;
      start_d   <= next_start_d;
      ref_up    <= next_ref_up;
      sensor_up <= next_sensor_up;
      busy      <= next_busy;
      powered   <= next_powered;
      rvalid    <= next_rvalid;
      rch       <= next_rch;
      one_shot  <= next_one_shot;
    end
  end

  assign link.busy      = busy;
  assign O_BUSY         = busy;
  assign O_RESULT_VALID = rvalid;
  assign O_RESULT_CH    = rch;
  assign O_ADC_POWERED  = powered;
endmodule // adc_seq_device

// file: adc_seq_host.sv
// host controller: writes channel selection and pulses conversion start
`timescale 1ns/1ps
module adc_seq_host
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_SRST,
  // link to device
  adc_seq_if.host                link,
  // user side command
  input  wire logic              I_REQ,
  input  wire logic [1:0]        I_MODE,
  input  wire logic [NUM_CH-1:0] I_CHANNELS,
  input  wire logic [NUM_CH-1:0] I_TEMP_MASK,
  input  wire logic              I_LONG_PULSE,
  output logic                   O_READY,
  output logic                   O_BUSY_SEEN
);
  host_state_t       state, next_state;
  logic [1:0]        mode, next_mode;
  logic [NUM_CH-1:0] chans, next_chans;
  logic [NUM_CH-1:0] tmask, next_tmask;
  logic              wr, next_wr;
  logic              cs_n, next_cs_n;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [CNT_W-1:0]  plen, next_plen;
  logic [3:0]        left, next_left;
  logic              ready, next_ready;
  logic              bseen, next_bseen;
  logic [3:0]        ones;

  always_comb begin
    ones = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      ones = ones + 4'(I_CHANNELS[i]);
    end
  end

  always_comb begin
    next_state = state;
    next_mode  = mode;
    next_chans = chans;
    next_tmask = tmask;
    next_wr    = 1'b0;
    next_cs_n  = cs_n;
    next_cnt   = cnt;
    next_plen  = plen;
    next_left  = left;
    next_ready = 1'b0;
    next_bseen = bseen | link.busy;
    case (state)
      HS_IDLE: begin
        next_ready = ~link.busy;
        // reserved mode is never passed on
        if (I_REQ && ready && I_MODE != MODE_RESERVED) begin
          next_mode  = I_MODE;
          next_chans = I_CHANNELS;
          next_tmask = I_TEMP_MASK;
          next_wr    = 1'b1;
          next_ready = 1'b0;
          next_bseen = 1'b0;
          next_left  = (I_MODE == MODE_ONE_SHOT) ? ones : 4'h1;
          next_plen  = I_LONG_PULSE ? CNT_W'(CYC_START_INTREF) : CNT_W'(CYC_START_VOLT);
          next_cnt   = '0;
          next_state = (I_MODE == MODE_AUTO_WRITE) ? HS_WAIT : HS_LOW;
        end
      end
      HS_LOW: begin
        // hold low for plen cycles: covers 20ns and 1.5us, and 50us only with I_LONG_PULSE
        next_cs_n = 1'b0;
        next_cnt  = cnt + CNT_W'(1);
        if (cnt == plen) begin
          next_cs_n = 1'b1;
          next_cnt  = '0;
          next_left = left - 4'h1;
          next_state = HS_WAIT;
        end
      end
      HS_WAIT: begin
        next_cnt = (cnt == '1) ? cnt : cnt + CNT_W'(1);
        if (!link.busy && cnt > CNT_W'(4)) begin
          next_cnt   = '0;
          next_state = (left != 4'h0) ? HS_LOW : HS_IDLE;
        end
      end
      default: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      state <= HS_IDLE;
      mode  <= MODE_RESET;
      chans <= '0;
      tmask <= '0;
      wr    <= 1'b0;
      cs_n  <= 1'b1;
      cnt   <= '0;
      plen  <= '0;
      left  <= 4'h0;
      ready <= 1'b0;
      bseen <= 1'b0;
    end else begin
      state <= next_state;
      mode  <= next_mode;
      chans <= next_chans;
      tmask <= next_tmask;
      wr    <= next_wr;
      cs_n  <= next_cs_n;
      cnt   <= next_cnt;
      plen  <= next_plen;
      left  <= next_left;
      ready <= next_ready;
      bseen <= next_bseen;
    end
  end

  assign link.clock_mode         = mode;
  assign link.channel_select     = chans;
  assign link.kind_temp          = tmask;
  assign link.conv_write         = wr;
  assign link.conversion_start_n = cs_n;
  assign link.adc_monitor_enable = 1'b1;
  assign O_READY                 = ready;
  assign O_BUSY_SEEN             = bseen;
endmodule // adc_seq_host

// file: adc_seq_asserts.sv
// concurrent checks on the link between sequencer and host
`timescale 1ns/1ps
module adc_seq_asserts
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic              I_CLK_SYS,
  input wire logic              I_SRST,
  // link signals
  input wire logic              conversion_start_n,
  input wire logic              busy,
  input wire logic [1:0]        clock_mode,
  input wire logic              conv_write,
  input wire logic [NUM_CH-1:0] channel_select,
  input wire logic [NUM_CH-1:0] kind_temp,
  input wire logic              adc_monitor_enable
);
  // worst single conversion: first temperature with reference and sensor power-up
  localparam int BUSY_MAX = CYC_REF_UP + CYC_SENSOR_UP + CYC_TEMP_CONV + 8;
  logic [15:0] busy_cnt;

  // saturates so a stuck busy cannot wrap back into the legal range
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !busy)
      busy_cnt <= 16'h0;
    else if (busy_cnt != 16'hffff)
      busy_cnt <= busy_cnt + 16'h1;
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);

  reset_busy_low_a: assert property ($fell(I_SRST) |-> !busy)
    else $error("busy high after reset");
  reset_mode_a: assert property ($fell(I_SRST) |-> clock_mode == MODE_RESET)
    else $error("clock mode not default after reset");
  write_starts_scan_a: assert property (conv_write && !busy && !$past(busy)
    && clock_mode == MODE_AUTO_WRITE && $past(clock_mode) == MODE_AUTO_WRITE
    && channel_select != '0 && adc_monitor_enable |=> busy)
    else $error("register write did not start a scan");
  pulse_starts_conv_a: assert property ($rose(conversion_start_n) && !busy
    && (clock_mode == MODE_AUTO_PULSE || clock_mode == MODE_ONE_SHOT)
    && $stable(clock_mode) |=> busy)
    else $error("start pulse did not raise busy");
  busy_min_len_a: assert property ($fell(busy) |-> busy_cnt >= CYC_VOLT_CONV)
    else $error("busy shorter than a conversion");
  busy_max_len_a: assert property ($fell(busy) && clock_mode == MODE_ONE_SHOT
    |-> busy_cnt <= BUSY_MAX)
    else $error("single conversion busy too long");
  reserved_idle_a: assert property (clock_mode != MODE_RESERVED)
    else $error("reserved clock mode reached the link");
  temp_busy_len_a: assert property ($fell(busy) && clock_mode == MODE_ONE_SHOT
    && channel_select != '0 && (channel_select & ~kind_temp) == '0
    |-> busy_cnt >= CYC_TEMP_CONV)
    else $error("temperature conversion busy too short");
  busy_has_cause_a: assert property ($rose(busy) |-> $past(conv_write)
    || ($past(conversion_start_n) && !$past(conversion_start_n, 2)))
    else $error("busy rose without write or start release");

  cover property ($rose(busy) && clock_mode == MODE_AUTO_WRITE);
  cover property ($rose(busy) && clock_mode == MODE_AUTO_PULSE);
  cover property ($rose(busy) && clock_mode == MODE_ONE_SHOT);
endmodule // adc_seq_asserts

// file: tb_top.sv
// self-checking bench joining host controller and sequencer over the link
`timescale 1ns/1ps
module tb_top
  import adc_seq_pkg::*;
  ;
  logic              I_CLK_SYS = 1'b0;
  logic              I_SRST    = 1'b1;
  logic              req       = 1'b0;
  logic [1:0]        mode      = 2'h0;
  logic [NUM_CH-1:0] chans     = '0;
  logic [NUM_CH-1:0] tmask     = '0;
  logic [NUM_CH-1:0] ref_ext   = '1;
  logic              long_p    = 1'b0;
  logic              res_valid;
  logic [3:0]        res_ch;
  logic              powered;
  logic              dev_busy;
  logic              ready;
  logic              busy_seen;
  logic              busy_hit  = 1'b0;
  logic              clr       = 1'b0;
  logic [3:0]        first_ch  = 4'h0;
  logic [3:0]        last_ch   = 4'h0;
  int                fail_count = 0;
  int                check_count = 0;
  int                cycles    = 0;
  int                nres      = 0;
  int                lat       = 0;
  int                bcnt      = 0;

  adc_seq_if u_adc_seq_if ();

  adc_seq_device u_adc_seq_device (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .link(u_adc_seq_if),
    .I_REF_EXTERNAL(ref_ext), .O_RESULT_VALID(res_valid), .O_RESULT_CH(res_ch),
    .O_ADC_POWERED(powered), .O_BUSY(dev_busy));

  adc_seq_host u_adc_seq_host (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .link(u_adc_seq_if), .I_REQ(req),
    .I_MODE(mode), .I_CHANNELS(chans), .I_TEMP_MASK(tmask), .I_LONG_PULSE(long_p),
    .O_READY(ready), .O_BUSY_SEEN(busy_seen));

  adc_seq_asserts u_adc_seq_asserts (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
    .conversion_start_n(u_adc_seq_if.conversion_start_n), .busy(u_adc_seq_if.busy),
    .clock_mode(u_adc_seq_if.clock_mode), .conv_write(u_adc_seq_if.conv_write),
    .channel_select(u_adc_seq_if.channel_select), .kind_temp(u_adc_seq_if.kind_temp),
    .adc_monitor_enable(u_adc_seq_if.adc_monitor_enable));

  initial begin
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // latency is counted from the link's busy rise to the first result strobe
  always @(posedge I_CLK_SYS) begin
    cycles <= cycles + 1;
    bcnt <= (u_adc_seq_if.busy === 1'b1) ? bcnt + 1 : 0;
    if (clr) begin
      busy_hit <= 1'b0;
      nres     <= 0;
    end else begin
      if (dev_busy === 1'b1)
        busy_hit <= 1'b1;
      if (res_valid === 1'b1) begin
        if (nres == 0) begin
          first_ch <= res_ch;
          lat <= bcnt;
        end
        last_ch <= res_ch;
        nres <= nres + 1;
      end
    end
    if (cycles == 30000) begin
      fail_count++;
      $display("[ERR] run length expected below 30000 seen 30000");
      wrap_up();
    end
  end

  // one host request, then wait for busy to come and go under a bound
  task automatic run(input logic [1:0] m, input logic [NUM_CH-1:0] c,
                     input logic [NUM_CH-1:0] t, input logic lp);
    int n;
    @(negedge I_CLK_SYS);
    mode = m;
    chans = c;
    tmask = t;
    long_p = lp;
    req = 1'b1;
    clr = 1'b1;
    n = 0;
    @(posedge I_CLK_SYS);
    while (ready !== 1'b1 && n < 100) begin
      @(posedge I_CLK_SYS);
      n++;
    end
    @(negedge I_CLK_SYS);
    req = 1'b0;
    clr = 1'b0;
    n = 0;
    while (busy_hit !== 1'b1 && n < 3000) begin
      @(negedge I_CLK_SYS);
      n++;
    end
    while (u_adc_seq_if.busy !== 1'b0 && n < 9000) begin
      @(negedge I_CLK_SYS);
      n++;
    end
    repeat (3) @(negedge I_CLK_SYS);
  endtask

  task automatic scen(input logic [1:0] m, input logic [NUM_CH-1:0] c,
                      input logic [NUM_CH-1:0] t, input logic lp, input int cnt,
                      input logic [3:0] f, input logic [3:0] l, input int nom);
    run(m, c, t, lp);
    check_val("result count", 16'(cnt), 16'(nres));
    check_val("first channel", {12'h0, f}, {12'h0, first_ch});
    check_val("last channel", {12'h0, l}, {12'h0, last_ch});
    check_rng("result latency", nom - 2, nom + 8, lat);
    check_val("busy output seen", 16'h1, {15'h0, busy_hit});
    check_val("adc powered after scan", 16'h0, {15'h0, powered});
    check_val("host saw busy", 16'h1, {15'h0, busy_seen});
  endtask

  initial begin
    repeat (3) @(posedge I_CLK_SYS);
    @(negedge I_CLK_SYS);
    I_SRST = 1'b0;
    repeat (2) @(negedge I_CLK_SYS);
    check_val("mode after reset", {14'h0, MODE_RESET}, {14'h0, u_adc_seq_if.clock_mode});
    // channel 3 alone uses the internal reference
    ref_ext = 11'h7f7;
    scen(MODE_AUTO_WRITE, 11'h005, 11'h000, 1'b0, 2, 4'h0, 4'h2, CYC_VOLT_CONV);
    scen(MODE_AUTO_PULSE, 11'h0c0, 11'h000, 1'b0, 2, 4'h6, 4'h7, CYC_VOLT_CONV);
    scen(MODE_ONE_SHOT, 11'h010, 11'h010, 1'b0, 1, 4'h4, 4'h4,
         CYC_REF_UP + CYC_SENSOR_UP + CYC_TEMP_CONV);
    scen(MODE_ONE_SHOT, 11'h010, 11'h010, 1'b0, 1, 4'h4, 4'h4, CYC_TEMP_CONV);
    // a second reset drops the reference, so the next internal-reference voltage is a first one
    @(negedge I_CLK_SYS);
    I_SRST = 1'b1;
    repeat (3) @(negedge I_CLK_SYS);
    I_SRST = 1'b0;
    repeat (2) @(negedge I_CLK_SYS);
    check_val("mode after second reset", {14'h0, MODE_RESET},
              {14'h0, u_adc_seq_if.clock_mode});
    scen(MODE_ONE_SHOT, 11'h002, 11'h000, 1'b0, 1, 4'h1, 4'h1, CYC_VOLT_CONV);
    scen(MODE_ONE_SHOT, 11'h008, 11'h000, 1'b1, 1, 4'h3, 4'h3, CYC_VOLT_CONV);
    scen(MODE_ONE_SHOT, 11'h008, 11'h000, 1'b0, 1, 4'h3, 4'h3, CYC_TRACK_CONV);
    run(MODE_RESERVED, 11'h001, 11'h000, 1'b0);
    check_val("busy in reserved mode", 16'h0, {15'h0, busy_hit});
    check_val("mode after reserved request", {14'h0, MODE_ONE_SHOT},
              {14'h0, u_adc_seq_if.clock_mode});
    wrap_up();
  end
endmodule // tb_top
